// file: core/ssq_sequencer.sv
// module: run-line, delay, soft-start ramp and servo logic for one channel
// Functional notes
// - hold run low until initialised and input good
// - shared run line waits for every peer
// - wait turn-on delay after run release
// - delays count on the shared time base
// - ramp target from zero to set point
// - rise under 0.25 ms skips the ramp
// - step count is rise time over 0.1 ms
// - discontinuous mode throughout the rise ramp
// - bottom gate off on reverse current in discontinuous mode
// - gpio released once output above uv
// - unfiltered uv passes a 70 us filter
// - servo enabled by config bit 6
// - servo moves dac one lsb per 90 ms
// - servo waits for max turn-on time
// - zero limit: ramp done, above uv, no oc
// - programmed conduction mode when servo may start
// - rise time capped at 1.3 s
`timescale 1ns/1ps
module ssq_sequencer
#(
	parameter int SERVO_PERIOD = ssq_pkg::SERVO_CYC
)
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic run_in,
	output logic run_out,
	output logic run_oe,
	input wire logic share_in,
	output logic share_out,
	output logic share_oe,
	input wire logic gpio_in,
	output logic gpio_out,
	output logic gpio_oe,
	input wire logic init_done,
	input wire logic vin_above_on,
	input wire logic rev_current,
	input wire logic vout_uv_filt,
	input wire logic vout_uv_raw,
	input wire logic output_overcurrent_flag,
	input wire logic [15:0] adc_vout,
	output logic [15:0] dac_code,
	output logic pwm_dcm,
	output logic pwm_active,
	output logic bottom_gate_off,
	output logic servo_active,
	output logic volt_range_fine
);
	import ssq_pkg::*;
	// ****************************************
	// declarations
	// ****************************************
	ssq_cfg_type cfg; // software settings
	ssq_state_type state;
	ssq_state_type next_state;
	logic [PIN_N-1:0] s1; // first stage, read by s2 only
	logic [PIN_N-1:0] s2;
	logic [PIN_N-1:0] s3;
	logic [PIN_N-1:0] pin; // agreed pin levels
	logic share_prev; // time-base edge detect
	logic share_tick; // one pulse per shared time-base period
	logic [6:0] div_cnt; // own time-base divider
	logic [15:0] tick_cnt; // delay count in time-base ticks
	logic [15:0] ton_cnt; // ticks since ramp start
	logic [4:0] bit_cnt; // divider iterations left
	logic [18:0] rem; // divider remainder
	logic [19:0] quo; // divider quotient
	logic [18:0] rem_sh;
	logic [3:0] step_sub; // ticks inside one step
	logic [17:0] elapsed; // ticks covered by steps so far
	logic [17:0] rise_eff; // capped rise time
	logic step_due;
	logic last_step;
	logic skip_ramp;
	logic engage_ok;
	logic [19:0] servo_cnt;
	logic servo_tick;
	logic uv_deg; // deglitched raw uv
	logic uv_sel;
	logic aw_full; // address held
	logic w_full; // data held
	logic [11:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [31:0] wr_old; // register word at the held write address
	logic [31:0] wr_new; // that word with the held write merged in
	// ****************************************
	// helpers
	// ****************************************
	// merge a write into an old word under byte strobes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		return r;
	endfunction : merge
	// pack the mode bits into their register word, shared by read and write paths
	function automatic logic [31:0] cfg_word(input ssq_cfg_type c);
		logic [31:0] r;
		r = 32'h00000000;
		r[CFG_CCM_BIT] = c.ccm;
		r[CFG_SERVO_BIT] = c.servo_en;
		r[CFG_RANGE_BIT] = c.range_fine;
		r[CFG_GPIO_EN_BIT] = c.gpio_en;
		r[CFG_UNF_BIT] = c.unf_sel;
		return r;
	endfunction : cfg_word
	// ****************************************
	// pin synchroniser
	// ****************************************
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
			pin <= '0;
		end
		else
		begin
			s1 <= {output_overcurrent_flag, vout_uv_filt, rev_current, vin_above_on, init_done, share_in,
				run_in};
			s2 <= s1;
			s3 <= s2;
			pin <= (s2 & s3) | (pin & (s2 ^ s3)); // change once two stages agree
		end
	end
	// raw uv path through its own filter
	ssq_deglitch u_deglitch
	(
		.clk(clk),
		.rstn(rstn),
		.raw(vout_uv_raw),
		.filt(uv_deg)
	);
	// ****************************************
	// shared time base
	// ****************************************
	// pull the line low for half our period; the fastest peer wins the line
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			div_cnt <= 7'h00;
			share_oe <= 1'b1;
			share_prev <= 1'b0;
		end
		else
		begin
			div_cnt <= (div_cnt == 7'(2 * SHARE_HALF_CYC - 1)) ? 7'h00 : div_cnt + 7'h01;
			share_oe <= !pin[PIN_INIT] || div_cnt < 7'(SHARE_HALF_CYC);
			share_prev <= pin[PIN_SHARE];
		end
	end
	assign share_tick = pin[PIN_SHARE] && !share_prev;
	assign share_out = 1'b0;
	// ****************************************
	// sequence state machine
	// ****************************************
	assign rise_eff = (cfg.rise > 18'(RISE_MAX_UNITS)) ? 18'(RISE_MAX_UNITS) : cfg.rise;
	assign skip_ramp = rise_eff < 18'(RISE_MIN_UNITS);
	assign step_due = share_tick && step_sub == 4'(STEP_TICKS - 1);
	assign last_step = ({1'b0, elapsed} + 19'(2 * STEP_TICKS)) > {1'b0, rise_eff};
	assign engage_ok = !pin[PIN_UV] && !pin[PIN_OC]
		&& (cfg.ton_max == 16'h0000 || ton_cnt >= cfg.ton_max);
	always_comb
	begin
		next_state = state;
		case (state)
			ST_HOLD: if (pin[PIN_INIT] && pin[PIN_VIN]) next_state = ST_WAIT;
			ST_WAIT: if (pin[PIN_RUN]) next_state = ST_DELAY;
			ST_DELAY: if (tick_cnt >= cfg.delay) next_state = skip_ramp ? ST_SETTLE : ST_DIV;
			ST_DIV: if (bit_cnt == 5'h00) next_state = ST_RAMP;
			ST_RAMP: if (step_due && last_step) next_state = ST_SETTLE;
			ST_SETTLE: if (engage_ok) next_state = ST_ON;
			ST_ON: next_state = ST_ON;
			default: next_state = ST_HOLD;
		endcase
		if (!(pin[PIN_INIT] && pin[PIN_VIN]))
			next_state = ST_HOLD;
		else if (!pin[PIN_RUN] && state != ST_HOLD)
			next_state = ST_WAIT;
	end
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			state <= ST_HOLD;
		else
			state <= next_state;
	end
	// ****************************************
	// delay and turn-on timers
	// ****************************************
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tick_cnt <= 16'h0000;
			ton_cnt <= 16'h0000;
		end
		else
		begin
			if (state != ST_DELAY)
				tick_cnt <= 16'h0000;
			else if (share_tick && tick_cnt != 16'hffff)
				tick_cnt <= tick_cnt + 16'h0001;
			if (state == ST_HOLD || state == ST_WAIT || state == ST_DELAY)
				ton_cnt <= 16'h0000;
			else if (share_tick && ton_cnt != 16'hffff)
				ton_cnt <= ton_cnt + 16'h0001;
		end
	end
	// ****************************************
	// step size: set point over step count
	// ****************************************
	assign rem_sh = {rem[17:0], quo[19]};
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			bit_cnt <= 5'h00;
			rem <= 19'h00000;
			quo <= 20'h00000;
		end
		else if (state == ST_DELAY)
		begin
			bit_cnt <= 5'h14;
			rem <= 19'h00000;
			quo <= 20'(cfg.vcmd * STEP_TICKS);
		end
		else if (state == ST_DIV && bit_cnt != 5'h00)
		begin
			bit_cnt <= bit_cnt - 5'h01;
			if (rem_sh >= {1'b0, rise_eff})
			begin
				rem <= rem_sh - {1'b0, rise_eff};
				quo <= {quo[18:0], 1'b1};
			end
			else
			begin
				rem <= rem_sh;
				quo <= {quo[18:0], 1'b0};
			end
		end
	end
	// ****************************************
	// ramp steps and servo period
	// ****************************************
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			step_sub <= 4'h0;
			elapsed <= 18'h00000;
			servo_cnt <= 20'h00000;
		end
		else
		begin
			if (state != ST_RAMP)
			begin
				step_sub <= 4'h0;
				elapsed <= 18'h00000;
			end
			else if (step_due)
			begin
				step_sub <= 4'h0;
				elapsed <= elapsed + 18'(STEP_TICKS);
			end
			else if (share_tick)
				step_sub <= step_sub + 4'h1;
			if (!servo_active || servo_tick)
				servo_cnt <= 20'h00000;
			else
				servo_cnt <= servo_cnt + 20'h00001;
		end
	end
	assign servo_tick = servo_active && servo_cnt == 20'(SERVO_PERIOD - 1);
	// target: zero, ramp, set point, then servo trim
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			dac_code <= 16'h0000;
		else if (next_state == ST_HOLD || next_state == ST_WAIT || state == ST_DELAY
			&& next_state != ST_SETTLE || state == ST_DIV)
			dac_code <= 16'h0000;
		else if (state == ST_DELAY)
			dac_code <= cfg.vcmd;
		else if (state == ST_RAMP && step_due)
			dac_code <= last_step ? cfg.vcmd : dac_code + quo[15:0];
		else if (servo_tick && adc_vout < cfg.vcmd && dac_code != 16'hffff)
			dac_code <= dac_code + 16'h0001;
		else if (servo_tick && adc_vout > cfg.vcmd && dac_code != 16'h0000)
			dac_code <= dac_code - 16'h0001;
	end
	// ****************************************
	// mode and pin outputs
	// ****************************************
	assign uv_sel = cfg.unf_sel ? uv_deg : pin[PIN_UV];
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			run_oe <= 1'b1;
			pwm_dcm <= 1'b1;
			pwm_active <= 1'b0;
			bottom_gate_off <= 1'b0;
			servo_active <= 1'b0;
			gpio_oe <= 1'b0;
		end
		else
		begin
			run_oe <= next_state == ST_HOLD;
			pwm_dcm <= (next_state == ST_ON) ? !cfg.ccm : 1'b1;
			pwm_active <= next_state == ST_RAMP || next_state == ST_SETTLE
				|| next_state == ST_ON;
			bottom_gate_off <= pwm_dcm && pin[PIN_REV];
			servo_active <= next_state == ST_ON && cfg.servo_en;
			gpio_oe <= cfg.gpio_en && uv_sel;
		end
	end
	assign run_out = 1'b0;
	assign gpio_out = 1'b0;
	assign volt_range_fine = cfg.range_fine;
	// ****************************************
	// axi4-lite slave
	// ****************************************
	assign awready = !aw_full && !bvalid;
	assign wready = !w_full && !bvalid;
	assign arready = !rvalid;
	// old word of the addressed register, then the strobed write laid over it
	always_comb
	begin
		case (aw_addr)
			ADDR_CFG: wr_old = cfg_word(cfg);
			ADDR_DELAY: wr_old = 32'(cfg.delay);
			ADDR_RISE: wr_old = 32'(cfg.rise);
			ADDR_TONMAX: wr_old = 32'(cfg.ton_max);
			ADDR_VCMD: wr_old = 32'(cfg.vcmd);
			default: wr_old = 32'h00000000; // read-only or unmapped
		endcase
		wr_new = merge(wr_old, w_data, w_strb);
	end
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			aw_addr <= 12'h000;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			cfg <= {5'h00, DELAY_RST, RISE_RST, TONMAX_RST, VCMD_RST};
		end
		else
		begin
			if (awvalid && awready)
			begin
				aw_full <= 1'b1;
				aw_addr <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_full <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			if (bvalid && bready)
				bvalid <= 1'b0;
			else if (aw_full && w_full)
			begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				bvalid <= 1'b1;
				bresp <= RESP_OKAY;
				case (aw_addr)
					ADDR_CFG:
					begin
						cfg.ccm <= wr_new[CFG_CCM_BIT];
						cfg.servo_en <= wr_new[CFG_SERVO_BIT];
						cfg.range_fine <= wr_new[CFG_RANGE_BIT];
						cfg.gpio_en <= wr_new[CFG_GPIO_EN_BIT];
						cfg.unf_sel <= wr_new[CFG_UNF_BIT];
					end
					ADDR_DELAY: cfg.delay <= wr_new[15:0];
					ADDR_RISE: cfg.rise <= wr_new[17:0];
					ADDR_TONMAX: cfg.ton_max <= wr_new[15:0];
					ADDR_VCMD: cfg.vcmd <= wr_new[15:0];
					default: bresp <= RESP_SLVERR; // read-only or unmapped
				endcase
			end
		end
	end
	// read side, one cycle after address
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= RESP_OKAY;
		end
		else if (rvalid && rready)
			rvalid <= 1'b0;
		else if (arvalid && arready)
		begin
			rvalid <= 1'b1;
			rresp <= RESP_OKAY;
			rdata <= 32'h00000000;
			case (araddr)
				ADDR_CFG: rdata <= cfg_word(cfg);
				ADDR_DELAY: rdata <= 32'(cfg.delay);
				ADDR_RISE: rdata <= 32'(cfg.rise);
				ADDR_TONMAX: rdata <= 32'(cfg.ton_max);
				ADDR_VCMD: rdata <= 32'(cfg.vcmd);
				ADDR_STATUS: rdata <= 32'(state) | (32'(pwm_dcm) << STAT_DCM_BIT)
					| (32'(servo_active) << STAT_SERVO_BIT)
					| (32'(dac_code) << STAT_DAC_LSB);
				ADDR_ADC: rdata <= 32'(adc_vout);
				default: rresp <= RESP_SLVERR;
			endcase
		end
	end
	// ****************************************
	// assertions
	// ****************************************
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rstn);
	run_held_a: assert property (!(pin[PIN_INIT] && pin[PIN_VIN]) |=> run_oe)
		else $error("run line released before init and input good");
	peer_wait_a: assert property ($rose(state == ST_DELAY) |-> $past(pin[PIN_RUN]))
		else $error("delay started while run line still low");
	delay_hold_a: assert property (state == ST_DELAY && tick_cnt < cfg.delay
		|=> state inside {ST_DELAY, ST_WAIT, ST_HOLD})
		else $error("ramp started before turn-on delay");
	tick_base_a: assert property (state == ST_DELAY && !share_tick && $past(state == ST_DELAY)
		|=> $stable(tick_cnt) || state != ST_DELAY)
		else $error("delay counted without a time-base edge");
	ramp_rise_a: assert property (state == ST_RAMP && $past(state == ST_RAMP)
		|-> dac_code >= $past(dac_code))
		else $error("ramp target fell");
	ramp_skip_a: assert property (state == ST_SETTLE && $past(state == ST_DELAY)
		|-> dac_code == cfg.vcmd)
		else $error("short rise did not jump to set point");
	step_time_a: assert property (state == ST_RAMP && !step_due
		|=> $stable(dac_code) || state inside {ST_HOLD, ST_WAIT})
		else $error("ramp target moved between steps");
	ramp_dcm_a: assert property (state inside {ST_DIV, ST_RAMP, ST_SETTLE} |-> pwm_dcm)
		else $error("continuous mode during rise");
	gate_off_a: assert property (pwm_dcm && pin[PIN_REV] |=> bottom_gate_off)
		else $error("bottom gate not cut on reverse current");
	gpio_off_a: assert property (!cfg.gpio_en |=> !gpio_oe)
		else $error("gpio pulled with release option off");
	servo_off_a: assert property (!cfg.servo_en && state == ST_ON && $past(state == ST_ON)
		|=> $stable(dac_code) || !$stable(cfg.servo_en) || state != ST_ON)
		else $error("dac trimmed with servo disabled");
	servo_step_a: assert property (servo_tick && adc_vout < cfg.vcmd && dac_code != 16'hffff
		|=> dac_code == $past(dac_code) + 16'h0001 || state != ST_ON)
		else $error("servo did not step up one lsb");
	servo_idle_a: assert property (servo_tick && adc_vout == cfg.vcmd
		|=> $stable(dac_code) || state != ST_ON)
		else $error("servo moved at zero error");
	engage_a: assert property ($rose(state == ST_ON) |-> $past(!pin[PIN_UV] && !pin[PIN_OC]
		&& (cfg.ton_max == 16'h0000 || ton_cnt >= cfg.ton_max)))
		else $error("servo point reached too early");
	mode_switch_a: assert property (state == ST_ON |-> pwm_dcm == !$past(cfg.ccm))
		else $error("conduction mode not applied at servo start");
	rise_cap_a: assert property (rise_eff <= 18'(RISE_MAX_UNITS))
		else $error("rise time above ceiling");
	on_cov: cover property ($rose(state == ST_ON));
	skip_cov: cover property (state == ST_DELAY ##1 state == ST_SETTLE);
	step_cov: cover property (state == ST_RAMP && step_due && last_step);
	servo_cov: cover property (servo_tick && adc_vout != cfg.vcmd);
endmodule : ssq_sequencer

// file: inc/ssq_pkg.sv
// package: constants and types of the soft-start sequencer
package ssq_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 100; // 10 MHz system clock
	localparam int SHARE_TICK_NS = 10000; // nominal shared time-base period
	localparam int SHARE_HALF_CYC = SHARE_TICK_NS / CLK_PERIOD_NS / 2;
	localparam int STEP_US = 100; // ramp step interval
	localparam int STEP_TICKS = STEP_US * 1000 / SHARE_TICK_NS;
	localparam int RISE_UNIT_US = SHARE_TICK_NS / 1000; // rise time lsb
	localparam int RISE_MIN_US = 250; // below this the ramp is skipped
	localparam int RISE_MIN_UNITS = RISE_MIN_US / RISE_UNIT_US;
	localparam int RISE_MAX_MS = 1300; // rise time ceiling
	localparam int RISE_MAX_UNITS = RISE_MAX_MS * 1000 / RISE_UNIT_US;
	localparam int GLITCH_US = 70; // unfiltered uv deglitch time
	localparam int GLITCH_CYC = (GLITCH_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SERVO_MS = 90; // servo step period
	localparam int SERVO_CYC = SERVO_MS * 1000000 / CLK_PERIOD_NS;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [11:0] ADDR_CFG = 12'h000;
	localparam logic [11:0] ADDR_DELAY = 12'h004;
	localparam logic [11:0] ADDR_RISE = 12'h008;
	localparam logic [11:0] ADDR_TONMAX = 12'h00c;
	localparam logic [11:0] ADDR_VCMD = 12'h010;
	localparam logic [11:0] ADDR_STATUS = 12'h014;
	localparam logic [11:0] ADDR_ADC = 12'h018;
	localparam int CFG_CCM_BIT = 0; // programmed conduction mode
	localparam int CFG_SERVO_BIT = 6; // servo enable
	localparam int CFG_RANGE_BIT = 8; // fine voltage range
	localparam int CFG_GPIO_EN_BIT = 9; // gpio release on uv
	localparam int CFG_UNF_BIT = 10; // unfiltered uv to gpio
	localparam int STAT_DCM_BIT = 8;
	localparam int STAT_SERVO_BIT = 9;
	localparam int STAT_DAC_LSB = 16;
	localparam logic [15:0] DELAY_RST = 16'h0000;
	localparam logic [17:0] RISE_RST = 18'h003e8;
	localparam logic [15:0] TONMAX_RST = 16'h0000;
	localparam logic [15:0] VCMD_RST = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ****************************************
	// pin inputs, index into synchroniser
	// ****************************************
	localparam int PIN_RUN = 0;
	localparam int PIN_SHARE = 1;
	localparam int PIN_INIT = 2;
	localparam int PIN_VIN = 3;
	localparam int PIN_REV = 4;
	localparam int PIN_UV = 5;
	localparam int PIN_OC = 6;
	localparam int PIN_N = 7;
	// ****************************************
	// types
	// ****************************************
	typedef struct packed {
		logic ccm;
		logic servo_en;
		logic range_fine;
		logic gpio_en;
		logic unf_sel;
		logic [15:0] delay;
		logic [17:0] rise;
		logic [15:0] ton_max;
		logic [15:0] vcmd;
	} ssq_cfg_type;
	typedef enum logic [6:0] {
		ST_HOLD = 7'h01,
		ST_WAIT = 7'h02,
		ST_DELAY = 7'h04,
		ST_DIV = 7'h08,
		ST_RAMP = 7'h10,
		ST_SETTLE = 7'h20,
		ST_ON = 7'h40
	} ssq_state_type;
endpackage : ssq_pkg

// file: core/ssq_deglitch.sv
// module: synchroniser and stability filter for the raw uv comparator
`timescale 1ns/1ps
module ssq_deglitch
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic raw,
	output logic filt
);
	import ssq_pkg::*;
	logic s1; // first stage, read by s2 only
	logic s2;
	logic s3;
	logic [9:0] cnt; // stable time so far
	// ****************************************
	// three-stage synchroniser
	// ****************************************
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end
		else
		begin
			s1 <= raw;
			s2 <= s1;
			s3 <= s2;
		end
	end
	// follow only after the new level has held the whole filter time
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt <= 10'h000;
			filt <= 1'b0;
		end
		else if (s2 != s3 || s3 == filt)
			cnt <= 10'h000; // disagreement or no change
		else if (cnt == 10'(GLITCH_CYC - 1))
		begin
			filt <= s3;
			cnt <= 10'h000;
		end
		else
			cnt <= cnt + 10'h001;
	end
	filt_hold_a: assert property (@(posedge clk) disable iff (!rstn)
		$changed(filt) |-> $past(cnt) == 10'(GLITCH_CYC - 1))
		else $error("uv filter output moved before the filter time");
endmodule : ssq_deglitch

// file: test/ssq_peer.sv
// file: model of a peer controller sharing the run and time-base lines
`timescale 1ns/1ps
module ssq_peer
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic not_ready,
	output logic run_pull,
	output logic share_pull
);
	// ****************************************
	// open-drain pulls, high = line pulled low
	// ****************************************
	// peer keeps run low until it is initialised itself
	always_ff @(posedge clk or negedge rstn)
		if (!rstn) run_pull <= 1'b1;
		else run_pull <= not_ready;
	// peer holds time base low until ready, then lets the fastest source clock it
	always_ff @(posedge clk or negedge rstn)
		if (!rstn) share_pull <= 1'b1;
		else share_pull <= not_ready;
endmodule : ssq_peer

// file: test/soft_start_sequencer_servo_tb.sv
// file: self-checking bench of the soft-start sequencer
`timescale 1ns/1ps
module soft_start_sequencer_servo_tb;
	import ssq_pkg::*;
	// ****************************************
	// signals
	// ****************************************
	logic clk, rstn, awvalid, wvalid, bready, arvalid, rready, init_done, vin_above_on;
	logic rev_current, vout_uv_filt, vout_uv_raw, output_overcurrent_flag, awready, wready, bvalid, arready;
	logic rvalid, run_out, run_oe, share_out, share_oe, gpio_out, gpio_oe, pwm_dcm, hold;
	logic pwm_active, bottom_gate_off, servo_active, volt_range_fine, run_pull, share_pull;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	logic [15:0] adc_vout, dac_code, last;
	wire run_in = !(run_oe || run_pull); // open-drain run line
	wire share_in = !(share_oe || share_pull); // open-drain time base
	wire gpio_in = !gpio_oe; // pulled up
	int fails = 0, checks_done = 0, cnt, n;
	localparam logic [15:0] VC = 16'h0500;
	ssq_sequencer #(.SERVO_PERIOD(20)) u_dut (.clk(clk), .rstn(rstn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.run_in(run_in), .run_out(run_out), .run_oe(run_oe), .share_in(share_in),
		.share_out(share_out), .share_oe(share_oe), .gpio_in(gpio_in),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe), .init_done(init_done),
		.vin_above_on(vin_above_on), .rev_current(rev_current),
		.vout_uv_filt(vout_uv_filt), .vout_uv_raw(vout_uv_raw), .output_overcurrent_flag(output_overcurrent_flag),
		.adc_vout(adc_vout), .dac_code(dac_code), .pwm_dcm(pwm_dcm),
		.pwm_active(pwm_active), .bottom_gate_off(bottom_gate_off),
		.servo_active(servo_active), .volt_range_fine(volt_range_fine));
	ssq_peer u_peer (.clk(clk), .rstn(rstn), .not_ready(hold), .run_pull(run_pull),
		.share_pull(share_pull));
	always #50 clk = !clk;
	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wt(input int c);
		repeat (c) @(posedge clk);
	endtask : wt
	// write, address and data offered together, each released when taken
	task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		chk(bresp, er);
		@(posedge clk);
	endtask : axw
	task automatic axr(input logic [11:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask : axr
	task automatic give_verdict;
		$display("checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict
	// ****************************************
	// watchdog
	// ****************************************
	initial
	begin
		wt(40000);
		fails++;
		give_verdict();
	end
	// ****************************************
	// main sequence
	// ****************************************
	initial
	begin
		{clk, rstn, awvalid, wvalid, bready, arvalid, rready, init_done, vin_above_on} = '0;
		{rev_current, vout_uv_raw, output_overcurrent_flag, awaddr, araddr, wdata, adc_vout} = '0;
		{vout_uv_filt, hold, wstrb} = 6'h3f;
		wt(2);
		rstn <= 1'b1;
		wt(20);
		axr(ADDR_RISE);
		chk(rd, 32'h3e8);
		axr(ADDR_STATUS);
		chk(rd & 32'h7f, 32'h01);
		chk(run_oe, 1'b1);
		chk({share_oe, run_out, share_out, gpio_out}, 4'b1000);
		axr(12'h01c);
		chk(rs, RESP_SLVERR);
		chk(rd, 32'h0);
		axw(ADDR_STATUS, 32'h0, RESP_SLVERR);
		init_done <= 1'b1;
		vin_above_on <= 1'b1;
		wt(20);
		chk({run_oe, run_in}, 2'b00);
		axr(ADDR_STATUS);
		chk(rd & 32'h7f, 32'h02);
		// same delay and set point for both passes: five-step ramp with servo, then skipped ramp with turn-on limit
		axw(ADDR_DELAY, 32'h5, RESP_OKAY);
		axw(ADDR_VCMD, VC, RESP_OKAY);
		for (int i = 0; i < 2; i++)
		begin
			axw(ADDR_CFG, i ? 32'h300 : 32'h241, RESP_OKAY);
			chk(volt_range_fine, i);
			axw(ADDR_RISE, i ? 32'h18 : 32'h32, RESP_OKAY);
			axw(ADDR_TONMAX, i ? 32'h8 : 32'h0, RESP_OKAY);
			vin_above_on <= 1'b1;
			adc_vout <= VC;
			hold <= 1'b0;
			for (cnt = 0; cnt < 2000 && pwm_active !== 1'b1; cnt++) @(posedge clk);
			chk(cnt >= 400 && cnt < 900, 1'b1);
			chk(pwm_dcm, 1'b1);
			rev_current <= 1'b1;
			last = 16'h0;
			n = 0;
			for (cnt = 0; cnt < 8000 && last !== VC; cnt++)
			begin
				if (dac_code !== last) n++;
				last = dac_code;
				@(posedge clk);
			end
			chk(n, i ? 1 : 5);
			wt(8);
			chk({pwm_dcm, bottom_gate_off, gpio_oe}, 3'b111);
			output_overcurrent_flag <= 1'b1;
			vout_uv_filt <= 1'b0;
			wt(50);
			chk({pwm_dcm, gpio_oe}, 2'b10);
			output_overcurrent_flag <= 1'b0;
			wt(40);
			axr(ADDR_STATUS);
			chk(rd & 32'h7f, i ? 32'h20 : 32'h40);
			wt(i ? 900 : 0);
			axr(ADDR_STATUS);
			chk(rd & 32'h7f, 32'h40);
			chk({pwm_dcm, bottom_gate_off, servo_active}, {i == 1, i == 1, i == 0});
			if (i == 0)
			begin
				adc_vout <= VC - 16'h1;
				for (cnt = 0; cnt < 60 && dac_code === VC; cnt++) @(posedge clk);
				chk(dac_code, VC + 16'h1);
				adc_vout <= VC;
				wt(60);
				chk(dac_code, VC + 16'h1);
				axr(ADDR_ADC);
				chk(rd, 32'(VC));
				axw(ADDR_CFG, 32'h641, RESP_OKAY);
				vout_uv_raw <= 1'b1;
				wt(300);
				chk(gpio_oe, 1'b0);
				vout_uv_raw <= 1'b0;
				wt(5);
				vout_uv_raw <= 1'b1;
				wt(750);
				chk(gpio_oe, 1'b1);
				vout_uv_raw <= 1'b0;
			end
			vin_above_on <= 1'b0;
			vout_uv_filt <= 1'b1;
			rev_current <= 1'b0;
			wt(20);
			chk({dac_code, run_oe}, {16'h0, 1'b1});
		end
		give_verdict();
	end
endmodule : soft_start_sequencer_servo_tb
